// ==== include/scpa_defs.svh ====
// Constants for the stack check and program-space address block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SCPA_DEFS_SVH
`define SCPA_DEFS_SVH
// APB byte offsets of the block's registers
`define SCPA_OFF_STACK_LIMIT  12'h000
`define SCPA_OFF_TABLE_PAGE   12'h004
`define SCPA_OFF_WINDOW_PAGE  12'h008
`define SCPA_OFF_CORE_CTRL    12'h00C
`define SCPA_OFF_STATUS       12'h010
`define SCPA_OFF_STACK_PTR    12'h014
// Field positions
`define SCPA_CORE_WIN_EN_BIT  2
`define SCPA_STAT_OVF_BIT     0
`define SCPA_STAT_UNF_BIT     1
`define SCPA_TBL_CFG_BIT      7
// Reset values; the stack limit has none on purpose
`define SCPA_RST_PAGE         8'h00
`define SCPA_RST_CORE         16'h0000
`define SCPA_RST_SP           16'h0800
// Lowest legal stack address (below it lies the SFR region)
`define SCPA_STACK_FLOOR      16'h0800
`endif

// ==== include/scpa_pkg.sv ====
// Types shared by the stack check and program-space address block.
// Assumes scpa_defs.svh is on the include path.
`include "scpa_defs.svh"
package scpa_pkg;
   // Stack operation requested by the pipeline
   typedef enum logic [3:0] {
      SCPA_OP_NONE = 4'b0001,
      SCPA_OP_PUSH = 4'b0010,
      SCPA_OP_POP  = 4'b0100,
      SCPA_OP_REF  = 4'b1000
   } scpa_op_e;
   // Kind of pushed word
   typedef enum logic [1:0] {
      SCPA_PUSH_DATA = 2'b00,
      SCPA_PUSH_CALL = 2'b01,
      SCPA_PUSH_EXC  = 2'b10
   } scpa_push_kind_e;
endpackage

// ==== include/scpa_stack_if.sv ====
// Carries stack check results from the checker to the top.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface scpa_stack_if;
   logic [15:0] sp;        // Stack pointer value
   logic [15:0] limit;     // Stack limit, bit 0 forced low
   logic        is_push;   // Push in progress
   logic        is_use;    // Any stack-pointer-based access
   logic        ovf;       // Overflow found
   logic        unf;       // Underflow found
   modport chk (input sp, limit, is_push, is_use, output ovf, unf);
   modport top (output sp, limit, is_push, is_use, input ovf, unf);
endinterface
`default_nettype wire

// ==== logic/scpa_stack_chk.sv ====
// Compares stack-pointer-based addresses with the limit and the floor.
// Assumes inputs are stable within the cycle that uses them.
`timescale 1ns/1ps
`default_nettype none
`include "scpa_defs.svh"
module scpa_stack_chk (
   scpa_stack_if.chk sif
);
   import scpa_pkg::*;
   // Overflow only when a push starts above the limit, so equality still pushes
   always_comb begin
      sif.ovf = sif.is_push && (sif.sp > sif.limit);
      sif.unf = sif.is_use && (sif.sp < `SCPA_STACK_FLOOR);
   end
endmodule
`default_nettype wire

// ==== logic/scpa_addr_gen.sv ====
// Forms 24-bit program addresses for table and window accesses.
// Assumes page registers are held by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "scpa_defs.svh"
module scpa_addr_gen (
   input  wire logic [15:0] ea,
   input  wire logic [7:0]  tbl_page,
   input  wire logic [7:0]  win_page,
   input  wire logic        win_en,
   output logic      [23:0] tbl_addr,
   output logic             tbl_cfg,
   output logic      [23:0] win_addr,
   output logic             win_hit
);
   import scpa_pkg::*;
   // Table address: page on top of the full effective address
   always_comb begin
      tbl_addr = {tbl_page, ea};
      tbl_cfg  = tbl_page[`SCPA_TBL_CFG_BIT];
   end
   // Window address: bit 23 zero, page fills 22:15, EA bit 15 dropped
   always_comb begin
      win_hit  = win_en && ea[15];
      win_addr = {1'b0, win_page, ea[14:0]};
   end
endmodule
`default_nettype wire

// ==== logic/scpa_top.sv ====
// Stack checker and program-space address generator with APB registers.
// Assumes the pipeline presents one stack operation per cycle, same clock.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "scpa_defs.svh"
// Operation
// - Pointer marks first free word, grows upward
// - Predecrement on pop, postincrement on push
// - Call push zero-extends counter top
// - Exception push adds status low byte
// - Stack limit has no reset value
// - Limit bit 0 reads and acts zero
// - Every pointer-based address checked against limit; only pushes are compared with it, other accesses only with the floor
// - Push at limit passes, next traps
// - Pointer below 0800h traps underflow
// - Program words 24 bits, data 16 bits
// - Table address joins page and EA
// - Table page top bit selects configuration space
// - Table reaches all bytes, window low word
// - Window read returns low word only
// - Window page joins low 15 EA bits
// - Window access stays in user memory
// - Program bit 15 from window page bit 0
// - Window active only when enabled and EA[15]
module scpa_top (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic      [31:0]            prdata,
   output logic                        pslverr,
   // Stack request from the pipeline
   input  wire scpa_pkg::scpa_op_e     stk_op,
   input  wire scpa_pkg::scpa_push_kind_e stk_kind,
   input  wire logic [15:0]            stk_wdata,
   input  wire logic [22:0]            stk_pc,
   input  wire logic [7:0]             status_low_byte,
   input  wire logic                   stk_pc_hi,
   output logic      [15:0]            stk_addr,
   output logic      [15:0]            stk_word,
   output logic                        stk_we,
   output logic                        stack_trap,
   // Data-space read that may map into program space
   input  wire logic                   rd_req,
   input  wire logic                   rd_table,
   input  wire logic [15:0]            rd_ea,
   input  wire logic [1:0]             rd_lane,
   output logic      [23:0]            prog_addr,
   output logic                        prog_cfg,
   output logic                        prog_req,
   input  wire logic [23:0]            prog_rdata,
   output logic      [15:0]            rd_data
);
   import scpa_pkg::*;

   logic [15:0] stack_pointer_reg;    // First free word
   logic [15:0] stack_limit_reg;      // Upper stack boundary
   logic [7:0]  table_page_reg;       // Table page
   logic [7:0]  window_page_reg;      // Window page
   logic [15:0] core_control_reg;     // Core control, bit 2 enables window
   logic [1:0]  trap_stat_reg;        // Sticky overflow / underflow
   logic [15:0] sp_eff;               // Address actually used by the access
   logic [23:0] tbl_addr;
   logic [23:0] win_addr;
   logic        tbl_cfg;
   logic        win_hit;
   logic        apb_wr;
   logic        apb_rd;
   logic        trap_now;

   scpa_stack_if sif ();

   // Zero-wait slave: answers in the access cycle
   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;

   // Address decode shared by read and write
   function automatic logic known_addr(input logic [11:0] a);
      known_addr = (a == `SCPA_OFF_STACK_LIMIT) || (a == `SCPA_OFF_TABLE_PAGE) ||
                   (a == `SCPA_OFF_WINDOW_PAGE) || (a == `SCPA_OFF_CORE_CTRL) ||
                   (a == `SCPA_OFF_STATUS) || (a == `SCPA_OFF_STACK_PTR);
   endfunction

   assign pslverr = psel && penable && !known_addr(paddr);

   // Effective address: pop uses the predecremented pointer
   always_comb begin
      if (stk_op == SCPA_OP_POP) begin
         sp_eff = stack_pointer_reg - 16'h0002;
      end else begin
         sp_eff = stack_pointer_reg;
      end
   end

   // Checker sees the access address for every pointer-based access
   assign sif.sp      = sp_eff;
   assign sif.limit   = {stack_limit_reg[15:1], 1'b0};
   assign sif.is_push = (stk_op == SCPA_OP_PUSH);
   assign sif.is_use  = (stk_op != SCPA_OP_NONE);

   scpa_stack_chk u_chk (
      .sif (sif)
   );

   assign trap_now = sif.ovf || sif.unf;

   scpa_addr_gen u_agen (
      .ea       (rd_ea),
      .tbl_page (table_page_reg),
      .win_page (window_page_reg),
      .win_en   (core_control_reg[`SCPA_CORE_WIN_EN_BIT]),
      .tbl_addr (tbl_addr),
      .tbl_cfg  (tbl_cfg),
      .win_addr (win_addr),
      .win_hit  (win_hit)
   );

   // Stack pointer: moves only on legal push or pop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_pointer_reg <= `SCPA_RST_SP;
      end else if (stk_op == SCPA_OP_PUSH && !trap_now) begin
         stack_pointer_reg <= stack_pointer_reg + 16'h0002;
      end else if (stk_op == SCPA_OP_POP && !trap_now) begin
         stack_pointer_reg <= sp_eff;
      end
   end

   // Limit has no reset so it stays undefined until software writes it
   always_ff @(posedge pclk) begin
      if (apb_wr && paddr == `SCPA_OFF_STACK_LIMIT) begin
         stack_limit_reg <= {pwdata[15:1], 1'b0};
      end
   end

   // Page and control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_page_reg   <= `SCPA_RST_PAGE;
         window_page_reg  <= `SCPA_RST_PAGE;
         core_control_reg <= `SCPA_RST_CORE;
      end else if (apb_wr) begin
         if (paddr == `SCPA_OFF_TABLE_PAGE) begin
            table_page_reg <= pwdata[7:0];
         end else if (paddr == `SCPA_OFF_WINDOW_PAGE) begin
            window_page_reg <= pwdata[7:0];
         end else if (paddr == `SCPA_OFF_CORE_CTRL) begin
            core_control_reg <= pwdata[15:0];
         end
      end
   end

   // Sticky trap causes; a new trap wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trap_stat_reg <= 2'b00;
      end else begin
         trap_stat_reg <= ((apb_wr && paddr == `SCPA_OFF_STATUS) ?
                           (trap_stat_reg & ~pwdata[1:0]) : trap_stat_reg) |
                          {sif.unf, sif.ovf};
      end
   end

   // Stack memory write, registered; one trap pulse per bad access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stk_addr   <= 16'h0000;
         stk_word   <= 16'h0000;
         stk_we     <= 1'b0;
         stack_trap <= 1'b0;
      end else begin
         stk_addr   <= sp_eff;
         stack_trap <= trap_now;
         stk_we     <= (stk_op == SCPA_OP_PUSH) && !trap_now;
         case (stk_kind)
            SCPA_PUSH_CALL: begin
               stk_word <= stk_pc_hi ? {9'h000, stk_pc[22:16]}
                                     : stk_pc[15:0];
            end
            SCPA_PUSH_EXC: begin
               stk_word <= stk_pc_hi ? {status_low_byte, 1'b0, stk_pc[22:16]}
                                     : stk_pc[15:0];
            end
            default: begin
               stk_word <= stk_wdata;
            end
         endcase
      end
   end

   // Program-space request: table wins, window suspended during table ops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_addr <= 24'h000000;
         prog_cfg  <= 1'b0;
         prog_req  <= 1'b0;
      end else begin
         prog_req <= rd_req && (rd_table || win_hit);
         if (rd_table) begin
            prog_addr <= tbl_addr;
            prog_cfg  <= tbl_cfg;
         end else begin
            prog_addr <= win_addr;
            prog_cfg  <= 1'b0;
         end
      end
   end

   // Read lane: table may pick the upper byte, window only the low word
   logic rd_table_q;
   logic [1:0] rd_lane_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_table_q <= 1'b0;
         rd_lane_q  <= 2'b00;
      end else begin
         rd_table_q <= rd_table;
         rd_lane_q  <= rd_lane;
      end
   end
   always_comb begin
      if (rd_table_q && rd_lane_q[1]) begin
         rd_data = {8'h00, prog_rdata[23:16]};
      end else begin
         rd_data = prog_rdata[15:0];
      end
   end

   // APB read data, registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_rd) begin
         if (paddr == `SCPA_OFF_STACK_LIMIT) begin
            prdata <= {16'h0000, stack_limit_reg[15:1], 1'b0};
         end else if (paddr == `SCPA_OFF_TABLE_PAGE) begin
            prdata <= {24'h000000, table_page_reg};
         end else if (paddr == `SCPA_OFF_WINDOW_PAGE) begin
            prdata <= {24'h000000, window_page_reg};
         end else if (paddr == `SCPA_OFF_CORE_CTRL) begin
            prdata <= {16'h0000, core_control_reg};
         end else if (paddr == `SCPA_OFF_STATUS) begin
            prdata <= {30'h00000000, trap_stat_reg};
         end else if (paddr == `SCPA_OFF_STACK_PTR) begin
            prdata <= {16'h0000, stack_pointer_reg};
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Checks
   sequence s_push_at_limit;
      (stk_op == SCPA_OP_PUSH) && (sp_eff == sif.limit) && (sp_eff >= `SCPA_STACK_FLOOR);
   endsequence
   property p_limit_push;
      @(posedge pclk) disable iff (!presetn) s_push_at_limit |=> !stack_trap;
   endproperty
   a_limit_push: assert property (p_limit_push) else $error("push at limit trapped");
   property p_over_push;
      @(posedge pclk) disable iff (!presetn)
         (stk_op == SCPA_OP_PUSH) && (sp_eff > sif.limit) |=> stack_trap && !stk_we;
   endproperty
   a_over_push: assert property (p_over_push) else $error("overflow not trapped");
   property p_under;
      @(posedge pclk) disable iff (!presetn)
         (stk_op != SCPA_OP_NONE) && (sp_eff < `SCPA_STACK_FLOOR) |=> stack_trap;
   endproperty
   a_under: assert property (p_under) else $error("underflow not trapped");
   property p_push_inc;
      @(posedge pclk) disable iff (!presetn)
         (stk_op == SCPA_OP_PUSH) && !trap_now |=>
            stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002 &&
            stk_addr == $past(stack_pointer_reg);
   endproperty
   a_push_inc: assert property (p_push_inc) else $error("push pointer wrong");
   property p_pop_dec;
      @(posedge pclk) disable iff (!presetn)
         (stk_op == SCPA_OP_POP) && !trap_now |=>
            stk_addr == $past(stack_pointer_reg) - 16'h0002 && stack_pointer_reg == stk_addr;
   endproperty
   a_pop_dec: assert property (p_pop_dec) else $error("pop not predecremented");
   property p_call_msb;
      @(posedge pclk) disable iff (!presetn)
         (stk_kind == SCPA_PUSH_CALL) && stk_pc_hi |=> stk_word[15:7] == 9'h000;
   endproperty
   a_call_msb: assert property (p_call_msb) else $error("call push top not clear");
   property p_exc_srl;
      @(posedge pclk) disable iff (!presetn)
         (stk_kind == SCPA_PUSH_EXC) && stk_pc_hi |=> stk_word[15:8] == $past(status_low_byte);
   endproperty
   a_exc_srl: assert property (p_exc_srl) else $error("status byte missing");
   property p_win_user;
      @(posedge pclk) disable iff (!presetn)
         rd_req && !rd_table && win_hit |=>
            prog_req && prog_addr[23] == 1'b0 && prog_addr[15] == $past(window_page_reg[0]);
   endproperty
   a_win_user: assert property (p_win_user) else $error("window address wrong");
   property p_tbl_addr;
      @(posedge pclk) disable iff (!presetn)
         rd_req && rd_table |=> prog_addr == {$past(table_page_reg), $past(rd_ea)} &&
                                prog_cfg == $past(table_page_reg[7]);
   endproperty
   a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
   property p_win_off;
      @(posedge pclk) disable iff (!presetn)
         rd_req && !rd_table && !core_control_reg[`SCPA_CORE_WIN_EN_BIT] |=> !prog_req;
   endproperty
   a_win_off: assert property (p_win_off) else $error("window used while disabled");
   // A refused access leaves the pointer alone, writes nothing, and pulses the trap
   property p_trap_hold;
      @(posedge pclk) disable iff (!presetn)
         trap_now |=> stack_pointer_reg == $past(stack_pointer_reg) && !stk_we && stack_trap;
   endproperty
   a_trap_hold: assert property (p_trap_hold) else $error("trap moved pointer");
   // A plain reference through the pointer is checked but never moves it
   property p_ref_hold;
      @(posedge pclk) disable iff (!presetn)
         (stk_op == SCPA_OP_REF) |=> stack_pointer_reg == $past(stack_pointer_reg) && !stk_we;
   endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("reference moved pointer");
   // Window reads hand back only the low word of the program word
   property p_win_low;
      @(posedge pclk) disable iff (!presetn)
         prog_req && !rd_table_q |-> rd_data == prog_rdata[15:0];
   endproperty
   a_win_low: assert property (p_win_low) else $error("window read not low word");
   // Limit writes keep bit 0 clear whatever software sends
   property p_limit_even;
      @(posedge pclk) disable iff (!presetn)
         apb_wr && (paddr == `SCPA_OFF_STACK_LIMIT) |=>
            {16'h0000, stack_limit_reg} == ($past(pwdata) & 32'h0000_FFFE);
   endproperty
   a_limit_even: assert property (p_limit_even) else $error("limit bit 0 not clear");
   // An overflow cause survives a clear that lands in the same cycle
   property p_stat_set;
      @(posedge pclk) disable iff (!presetn)
         sif.ovf |=> trap_stat_reg[`SCPA_STAT_OVF_BIT];
   endproperty
   a_stat_set: assert property (p_stat_set) else $error("overflow cause lost");
endmodule
`default_nettype wire

// ==== tb/scpa_mem_model.sv ====
// Program memory model on the far side of the program-space read port.
// Assumes the pipeline takes rd_data in the cycle that prog_req stands.
`timescale 1ns/1ps
`default_nettype none
module scpa_mem_model (
   input  wire logic        pclk,
   input  wire logic        prog_req,
   input  wire logic [23:0] prog_addr,
   output logic      [23:0] prog_rdata
);
   logic [23:0] junk_reg;  // Changing pattern while no word is addressed
   // Junk flips every cycle so a stale word can never look valid
   always @(posedge pclk) begin
      junk_reg <= ~junk_reg ^ 24'h5A5A5A;
   end
   initial begin
      junk_reg = 24'h0F0F0F;
   end
   // Each word is 24 bits wide, derived from its address
   assign prog_rdata = prog_req ? {prog_addr[7:0] ^ 8'h3C, prog_addr[15:0] ^ 16'hC35A}
                                : junk_reg;
endmodule
`default_nettype wire

// ==== tb/scpa_bench.sv ====
// Self-checking bench of the stack checker and program-space address block.
// Assumes scpa_pkg is compiled first and the memory model stands beside the design.
`timescale 1ns/1ps
`default_nettype none
module scpa_bench;
   import scpa_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;                  // APB address
   logic [31:0] pwdata, prdata;         // APB data
   scpa_op_e        stk_op;             // Stack operation
   scpa_push_kind_e stk_kind;           // Push kind
   logic [15:0] stk_wdata, stk_addr, stk_word, rd_ea, rd_data;
   logic [22:0] stk_pc;                 // Program counter
   logic [7:0]  status_low_byte;        // Status byte for exception push
   logic        stk_pc_hi, stk_we, stack_trap, rd_req, rd_table, prog_cfg, prog_req;
   logic [1:0]  rd_lane;                // Byte lane select
   logic [23:0] prog_addr, prog_rdata;  // Program bus
   int          miscompares, n_compared, cycles;
   logic [31:0] rv;                     // Read value
   logic        re;                     // Read error flag
   scpa_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .stk_op(stk_op), .stk_kind(stk_kind), .stk_wdata(stk_wdata),
      .stk_pc(stk_pc), .status_low_byte(status_low_byte), .stk_pc_hi(stk_pc_hi),
      .stk_addr(stk_addr), .stk_word(stk_word), .stk_we(stk_we), .stack_trap(stack_trap),
      .rd_req(rd_req), .rd_table(rd_table), .rd_ea(rd_ea), .rd_lane(rd_lane),
      .prog_addr(prog_addr), .prog_cfg(prog_cfg), .prog_req(prog_req),
      .prog_rdata(prog_rdata), .rd_data(rd_data));
   scpa_mem_model mem (.pclk(pclk), .prog_req(prog_req), .prog_addr(prog_addr),
      .prog_rdata(prog_rdata));
   // Free-running clock, 10 ns period
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Hang guard: the whole run needs well under this many cycles
   always @(posedge pclk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t timeout", $time);
         give_verdict();
      end
   end
   // Compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One APB transfer; waits on pready, takes data at the sampling edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Register read with expected value and error flag
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
      apb(1'b0, a, 32'h0000_0000, rv, re);
      chk(rv, exp, "register read");
      chk({31'h0, re}, {31'h0, eerr}, "slave error");
   endtask
   // One stack operation, judged in the cycle after it is taken
   task automatic stk(input scpa_op_e op, input scpa_push_kind_e k, input logic [15:0] ea,
                      input logic we, input logic tr, input logic [15:0] w);
      @(posedge pclk);
      stk_op   <= op;
      stk_kind <= k;
      @(posedge pclk);
      stk_op   <= SCPA_OP_NONE;
      #1;
      chk({31'h0, stack_trap}, {31'h0, tr}, "trap");
      chk({31'h0, stk_we}, {31'h0, we}, "write strobe");
      if (tr === 1'b0) chk({16'h0, stk_addr}, {16'h0, ea}, "stack address");
      if (we === 1'b1) chk({16'h0, stk_word}, {16'h0, w}, "stack word");
   endtask
   // One program-space read, judged while prog_req stands
   task automatic prd(input logic tb, input logic [15:0] ea, input logic [1:0] ln,
                      input logic req, input logic [23:0] pa, input logic cfg);
      logic [23:0] word;
      word = {pa[7:0] ^ 8'h3C, pa[15:0] ^ 16'hC35A};
      @(posedge pclk);
      rd_req   <= 1'b1;
      rd_table <= tb;
      rd_ea    <= ea;
      rd_lane  <= ln;
      @(posedge pclk);
      rd_req   <= 1'b0;
      #1;
      chk({31'h0, prog_req}, {31'h0, req}, "program request");
      if (req === 1'b1) begin
         chk({8'h0, prog_addr}, {8'h0, pa}, "program address");
         chk({31'h0, prog_cfg}, {31'h0, cfg}, "config space");
         if (tb === 1'b1 && ln[1] === 1'b1) chk({16'h0, rd_data}, {24'h0, word[23:16]}, "upper byte");
         else chk({16'h0, rd_data}, {16'h0, word[15:0]}, "low word");
      end
   endtask
   // Reset values, unmapped address, limit bit 0
   task automatic t_regs;
      rd_chk(12'h004, 32'h0000_0000, 1'b0);
      rd_chk(12'h008, 32'h0000_0000, 1'b0);
      rd_chk(12'h00C, 32'h0000_0000, 1'b0);
      rd_chk(12'h014, 32'h0000_0800, 1'b0);
      rd_chk(12'h0FC, 32'h0000_0000, 1'b1);
      apb(1'b1, 12'h000, 32'h0000_0805, rv, re);
      rd_chk(12'h000, 32'h0000_0804, 1'b0);
      $display("test regs done");
   endtask
   // Pushes up to the limit and one past it, then status clear
   task automatic t_push;
      stk_wdata <= 16'hBEEF;
      stk(SCPA_OP_PUSH, SCPA_PUSH_DATA, 16'h0800, 1'b1, 1'b0, 16'hBEEF);
      stk(SCPA_OP_PUSH, SCPA_PUSH_DATA, 16'h0802, 1'b1, 1'b0, 16'hBEEF);
      stk(SCPA_OP_PUSH, SCPA_PUSH_DATA, 16'h0804, 1'b1, 1'b0, 16'hBEEF);
      stk(SCPA_OP_PUSH, SCPA_PUSH_DATA, 16'h0806, 1'b0, 1'b1, 16'h0000);
      rd_chk(12'h014, 32'h0000_0806, 1'b0);
      rd_chk(12'h010, 32'h0000_0001, 1'b0);
      apb(1'b1, 12'h010, 32'h0000_0003, rv, re);
      rd_chk(12'h010, 32'h0000_0000, 1'b0);
      $display("test push done");
   endtask
   // Pops down to the floor and one below it
   task automatic t_pop;
      stk(SCPA_OP_POP, SCPA_PUSH_DATA, 16'h0804, 1'b0, 1'b0, 16'h0000);
      stk(SCPA_OP_POP, SCPA_PUSH_DATA, 16'h0802, 1'b0, 1'b0, 16'h0000);
      stk(SCPA_OP_POP, SCPA_PUSH_DATA, 16'h0800, 1'b0, 1'b0, 16'h0000);
      stk(SCPA_OP_POP, SCPA_PUSH_DATA, 16'h07FE, 1'b0, 1'b1, 16'h0000);
      stk(SCPA_OP_REF, SCPA_PUSH_DATA, 16'h0800, 1'b0, 1'b0, 16'h0000);
      rd_chk(12'h014, 32'h0000_0800, 1'b0);
      rd_chk(12'h010, 32'h0000_0002, 1'b0);
      $display("test pop done");
   endtask
   // Call and exception pushes of the program counter
   task automatic t_call;
      stk_pc          <= 23'h7F1234;
      status_low_byte <= 8'hA5;
      stk_pc_hi       <= 1'b1;
      stk(SCPA_OP_PUSH, SCPA_PUSH_CALL, 16'h0800, 1'b1, 1'b0, 16'h007F);
      stk(SCPA_OP_PUSH, SCPA_PUSH_EXC, 16'h0802, 1'b1, 1'b0, 16'hA57F);
      @(posedge pclk);
      stk_pc_hi       <= 1'b0;
      stk(SCPA_OP_PUSH, SCPA_PUSH_CALL, 16'h0804, 1'b1, 1'b0, 16'h1234);
      $display("test call done");
   endtask
   // Table and window address forming
   task automatic t_prog;
      apb(1'b1, 12'h004, 32'h0000_0081, rv, re);
      prd(1'b1, 16'h1234, 2'b00, 1'b1, 24'h811234, 1'b1);
      prd(1'b1, 16'h9ABC, 2'b10, 1'b1, 24'h819ABC, 1'b1);
      apb(1'b1, 12'h004, 32'h0000_0001, rv, re);
      prd(1'b1, 16'h0002, 2'b00, 1'b1, 24'h010002, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_00FF, rv, re);
      prd(1'b0, 16'h9234, 2'b00, 1'b0, 24'h000000, 1'b0);
      apb(1'b1, 12'h00C, 32'h0000_0004, rv, re);
      prd(1'b0, 16'h9234, 2'b10, 1'b1, 24'h7F9234, 1'b0);
      prd(1'b0, 16'h1234, 2'b00, 1'b0, 24'h000000, 1'b0);
      apb(1'b1, 12'h008, 32'h0000_0000, rv, re);
      prd(1'b0, 16'hF00E, 2'b00, 1'b1, 24'h00700E, 1'b0);
      $display("test prog done");
   endtask
   // Prints the counts and the verdict, then ends the run
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial begin
      miscompares = 0;
      n_compared = 0;
      cycles = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      stk_op = SCPA_OP_NONE;
      stk_kind = SCPA_PUSH_DATA;
      {stk_wdata, stk_pc, status_low_byte, stk_pc_hi} = '0;
      {rd_req, rd_table, rd_ea, rd_lane} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_push();
      t_pop();
      t_call();
      t_prog();
      give_verdict();
   end
endmodule
`default_nettype wire
